// ===== rtl/sdmc_device.sv
/*
 * Converter front end: shifts the 16-bit control word on falling serial
 * edges, holds the code and mode, shows output termination and power state.
 * Assumes the host keeps the link rules; runs only on the serial clock.
 */
`default_nettype none
module sdmc_device
    import sdmc_pkg::*;
(
    sdmc_link_if.device      link,
    input  wire logic        por_n,        // Power-on reset, active low
    output logic [11:0]      dac_code,     // Code driving the string
    output sdmc_mode_type    op_mode,
    output logic             analog_on,    // Bias, amplifier and string enabled
    output logic             term_1k,      // 1k pulldown applied
    output logic             term_100k,    // 100k pulldown applied
    output logic             out_hiz,      // Output high impedance
    output logic             frame_done    // Level toggles per accepted frame
);
    // ------------------------------------------------------------------
    // Shift path
    // ------------------------------------------------------------------
    logic [15:0] shift_reg;
    logic [4:0]  bit_cnt_reg;
    logic [15:0] word_next;

    assign word_next = {shift_reg[14:0], link.din};

    // Frame sync high clears the count asynchronously: an early rise aborts
    always_ff @(negedge link.sclk or posedge link.sync_n or negedge por_n) begin
        if (!por_n) begin
            shift_reg   <= 16'h0000;
            bit_cnt_reg <= SDMC_BITCNT_RESET;
        end else if (link.sync_n) begin
            shift_reg   <= 16'h0000;
            bit_cnt_reg <= SDMC_BITCNT_RESET;
        end else if (bit_cnt_reg < 5'(SDMC_FRAME_BITS)) begin
            shift_reg   <= word_next;
            bit_cnt_reg <= bit_cnt_reg + 5'd1;
        end
    end

    // Code and mode land together on the sixteenth falling edge
    always_ff @(negedge link.sclk or negedge por_n) begin
        if (!por_n) begin
            dac_code   <= SDMC_CODE_RESET;
            op_mode    <= SDMC_MODE_NORMAL;
            frame_done <= 1'b0;
        end else if (!link.sync_n && bit_cnt_reg == 5'(SDMC_FRAME_BITS - 1)) begin
            dac_code   <= word_next[SDMC_CODE_BITS-1:0];
            op_mode    <= sdmc_mode_type'(word_next[SDMC_MODE_MSB:SDMC_MODE_LSB]);
            frame_done <= ~frame_done;
        end
    end

    // ------------------------------------------------------------------
    // Output stage control; code still loads from power-down frames
    // ------------------------------------------------------------------
    assign analog_on = (op_mode == SDMC_MODE_NORMAL);
    assign term_1k   = (op_mode == SDMC_MODE_PD_1K);
    assign term_100k = (op_mode == SDMC_MODE_PD_100K);
    assign out_hiz   = (op_mode == SDMC_MODE_PD_HIZ);
endmodule : sdmc_device
`default_nettype wire

// ===== rtl/sdmc_host.sv
/*
 * Host controller: AHB-Lite slave with data, status and control registers;
 * sends 16-bit frames MSB first, in one word or as two bytes, and enforces
 * the wake-up wait and idle-low lines. Assumes one 125 MHz clock domain.
 */
`default_nettype none
module sdmc_host
    import sdmc_pkg::*;
#(
    parameter int WAKE_CYC = SDMC_WAKE_CYC
)(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    sdmc_link_if.host        link
);
    // ------------------------------------------------------------------
    // ------------------------------------------------------------------

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;
    logic        ctrl_byte_mode_reg;     // 1: send as two bytes
    logic [15:0] tx_word_reg;
    logic        tx_start_reg;
    logic        busy_reg;
    logic        waking_reg;
    logic [1:0]  last_mode_reg;
    logic        addr_ok;

    assign addr_ok   = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Capture write address phase
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            wr_addr_reg <= haddr;
        end
    end

    // Read data registered in the address phase
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            unique case (haddr)
                SDMC_ADDR_DATA:   hrdata <= {16'h0000, tx_word_reg};
                SDMC_ADDR_STATUS: hrdata <= {28'h0, last_mode_reg, waking_reg, busy_reg};
                SDMC_ADDR_CTRL:   hrdata <= {31'h0, ctrl_byte_mode_reg};
                default:          hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Register writes; data write while busy or waking is dropped
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_byte_mode_reg <= 1'b0;
            tx_word_reg        <= 16'h0000;
            tx_start_reg       <= 1'b0;
        end else begin
            tx_start_reg <= 1'b0;
            if (wr_pend_reg && wr_addr_reg == SDMC_ADDR_CTRL)
                ctrl_byte_mode_reg <= hwdata[0];
            if (wr_pend_reg && wr_addr_reg == SDMC_ADDR_DATA && !busy_reg && !waking_reg
                && !tx_start_reg) begin
                tx_word_reg  <= hwdata[15:0];
                tx_start_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Serial engine
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SDMC_ST_IDLE = 3'b000,
        SDMC_ST_LOW  = 3'b001,
        SDMC_ST_HIGH = 3'b010,
        SDMC_ST_GAP  = 3'b011,
        SDMC_ST_END  = 3'b100
    } sdmc_state_type;

    sdmc_state_type st_reg;
    logic [3:0]  div_reg;
    logic [4:0]  bits_reg;
    logic [7:0]  gap_reg;
    logic [15:0] sh_reg;
    logic        div_hit;

    assign div_hit = (div_reg == 4'(SDMC_HALF_PERIOD - 1));

    // Half-period divider makes the serial clock
    always_ff @(posedge clk) begin
        if (!reset_n || st_reg == SDMC_ST_IDLE || div_hit)
            div_reg <= 4'h0;
        else
            div_reg <= div_reg + 4'h1;
    end

    // Frame sequencer: data changes on rising edges, sampled on falling
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_reg      <= SDMC_ST_IDLE;
            link.sclk   <= 1'b0;
            link.sync_n <= 1'b0;
            link.din    <= 1'b0;
            bits_reg    <= 5'h00;
            gap_reg     <= 8'h00;
            sh_reg      <= 16'h0000;
            busy_reg    <= 1'b0;
        end else begin
            unique case (st_reg)
                SDMC_ST_IDLE: if (tx_start_reg) begin
                    busy_reg    <= 1'b1;
                    link.sync_n <= 1'b0;
                    link.sclk   <= 1'b1;
                    link.din    <= tx_word_reg[15];
                    sh_reg      <= {tx_word_reg[14:0], 1'b0};
                    bits_reg    <= 5'h00;
                    st_reg      <= SDMC_ST_HIGH;
                end
                SDMC_ST_HIGH: if (div_hit) begin
                    link.sclk <= 1'b0;
                    bits_reg  <= bits_reg + 5'h01;
                    st_reg    <= (bits_reg == 5'(SDMC_FRAME_BITS - 1)) ? SDMC_ST_END
                               : (ctrl_byte_mode_reg && bits_reg == 5'd7) ? SDMC_ST_GAP
                               : SDMC_ST_LOW;
                end
                SDMC_ST_LOW: if (div_hit) begin
                    link.sclk <= 1'b1;
                    link.din  <= sh_reg[15];
                    sh_reg    <= {sh_reg[14:0], 1'b0};
                    st_reg    <= SDMC_ST_HIGH;
                end
                SDMC_ST_GAP: if (div_hit) begin
                    // Pause between bytes with sync held low
                    st_reg <= SDMC_ST_LOW;
                end
                SDMC_ST_END: if (div_hit) begin
                    if (gap_reg == 8'h00)
                        link.sync_n <= 1'b1;
                    if (gap_reg == 8'(SDMC_SYNC_HIGH_CYC / SDMC_HALF_PERIOD + 1)) begin
                        link.sync_n <= 1'b0;
                        link.din    <= 1'b0;
                        gap_reg     <= 8'h00;
                        busy_reg    <= 1'b0;
                        st_reg      <= SDMC_ST_IDLE;
                    end else begin
                        gap_reg <= gap_reg + 8'h01;
                    end
                end
                default: st_reg <= SDMC_ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Wake-up wait after a power-down to normal command
    // ------------------------------------------------------------------
    logic [31:0] wake_cnt_reg;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            last_mode_reg <= 2'b00;
            waking_reg    <= 1'b0;
            wake_cnt_reg  <= 32'h0;
        end else if (tx_start_reg) begin
            last_mode_reg <= tx_word_reg[SDMC_MODE_MSB:SDMC_MODE_LSB];
            if (last_mode_reg != 2'b00
                && tx_word_reg[SDMC_MODE_MSB:SDMC_MODE_LSB] == 2'b00) begin
                waking_reg   <= 1'b1;
                wake_cnt_reg <= 32'(WAKE_CYC);
            end
        end else if (waking_reg && !busy_reg) begin
            // Output is not valid until the count runs out
            if (wake_cnt_reg == 32'h0)
                waking_reg <= 1'b0;
            else
                wake_cnt_reg <= wake_cnt_reg - 32'h1;
        end
    end
endmodule : sdmc_host
`default_nettype wire

// ===== rtl/sdmc_link_if.sv
/*
 * Three-wire write-only link between host controller and converter.
 * Assumes the host makes the serial clock; the device only listens.
 */
`default_nettype none
interface sdmc_link_if;
    logic sclk;      // Serial clock, host-made
    logic sync_n;    // Frame sync, active low
    logic din;       // Serial data, MSB first
    modport host   (output sclk, output sync_n, output din);
    modport device (input sclk, input sync_n, input din);
endinterface : sdmc_link_if
`default_nettype wire

// ===== rtl/sdmc_pkg.sv
/*
 * Shared constants for the serial converter front end and its host controller.
 * Assumes a 125 MHz system clock on the host side and a host-made serial clock.
 */
`default_nettype none
package sdmc_pkg;
    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam int          SDMC_FRAME_BITS   = 16;
    localparam int          SDMC_CODE_BITS    = 12;
    localparam int          SDMC_MODE_MSB     = 13;
    localparam int          SDMC_MODE_LSB     = 12;
    localparam logic [11:0] SDMC_CODE_RESET   = 12'h000;
    localparam logic [4:0]  SDMC_BITCNT_RESET = 5'h00;

    // Operating modes
    typedef enum logic [1:0] {
        SDMC_MODE_NORMAL = 2'b00,
        SDMC_MODE_PD_1K  = 2'b01,
        SDMC_MODE_PD_100K = 2'b10,
        SDMC_MODE_PD_HIZ = 2'b11
    } sdmc_mode_type;

    // ------------------------------------------------------------------
    // Host timing
    // ------------------------------------------------------------------
    localparam int          SDMC_CLK_MHZ       = 125;
    localparam int          SDMC_HALF_PERIOD   = 4;     // Clock cycles per serial half period
    localparam int          SDMC_SYNC_HIGH_NS  = 48;    // Frame sync high time between frames
    localparam int          SDMC_SYNC_HIGH_CYC =
        (SDMC_SYNC_HIGH_NS * SDMC_CLK_MHZ + 999) / 1000;
    localparam int          SDMC_WAKE_US       = 6;     // Wake-up interval, plain default
    localparam int          SDMC_WAKE_CYC      = SDMC_WAKE_US * SDMC_CLK_MHZ;

    // Host register map (AHB-Lite byte addresses)
    localparam logic [7:0]  SDMC_ADDR_DATA     = 8'h00;
    localparam logic [7:0]  SDMC_ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  SDMC_ADDR_CTRL     = 8'h08;
endpackage : sdmc_pkg
`default_nettype wire

// ===== test/sdmc_link_monitor.sv
/*
 * Checker beside the serial link and the converter outputs.
 * Assumes host signals change on clk and the device acts on falling sclk.
 */
`default_nettype none
module sdmc_link_monitor
    import sdmc_pkg::*;
(
    input wire logic          clk,
    input wire logic          reset_n,
    input wire logic          por_n,
    input wire logic          sclk,
    input wire logic          sync_n,
    input wire logic          din,
    input wire logic [11:0]   dac_code,
    input wire sdmc_mode_type op_mode,
    input wire logic          analog_on,
    input wire logic          term_1k,
    input wire logic          term_100k,
    input wire logic          out_hiz,
    input wire logic          frame_done
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Reference shifter
    // ------------------------------------------------------------------
    logic [14:0] sh_reg;
    logic [4:0]  cnt_reg;
    logic [13:0] word_reg;
    // Own copy of the word; kept after sync_n rises so late sampling works
    // Power-on clear too: sync_n idles low, so without it the count stays unknown
    always_ff @(negedge sclk or posedge sync_n or negedge por_n) begin
        if (!por_n || sync_n) begin
            cnt_reg <= 5'h00;
        end else if (cnt_reg < 5'h10) begin
            sh_reg  <= {sh_reg[13:0], din};
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == 5'h0f) begin
                word_reg <= {sh_reg[12:0], din};
            end
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_power_decode;
        @(posedge clk) disable iff (!por_n) analog_on == (op_mode == SDMC_MODE_NORMAL);
    endproperty
    a_power_decode: assert property (p_power_decode) else $error("power state wrong");
    property p_term_decode;
        @(posedge clk) disable iff (!por_n)
            {term_1k, term_100k, out_hiz} == {op_mode == 2'b01, op_mode == 2'b10, &op_mode};
    endproperty
    a_term_decode: assert property (p_term_decode) else $error("termination wrong");
    property p_frame_load;
        @(posedge clk) disable iff (!por_n || !reset_n)
            $changed(frame_done) |-> dac_code == word_reg[11:0] && op_mode == word_reg[13:12];
    endproperty
    a_frame_load: assert property (p_frame_load) else $error("frame load wrong");
    property p_hold_outputs;
        @(posedge clk) disable iff (!por_n || !reset_n)
            ($changed(dac_code) || $changed(op_mode)) |-> $changed(frame_done);
    endproperty
    a_hold_outputs: assert property (p_hold_outputs) else $error("output moved");
    property p_por_zero;
        @(posedge clk) disable iff (!reset_n)
            $rose(por_n) |-> dac_code == 12'h000 && op_mode == SDMC_MODE_NORMAL && !frame_done;
    endproperty
    a_por_zero: assert property (p_por_zero) else $error("power-on state wrong");
    property p_sync_gap;
        @(posedge clk) disable iff (!reset_n) $rose(sync_n) |-> sync_n [*6];
    endproperty
    a_sync_gap: assert property (p_sync_gap) else $error("sync high too short");
    property p_idle_low;
        @(posedge clk) disable iff (!reset_n)
            $rose(sync_n) |-> ##[6:40] (!sync_n && !din && !sclk);
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("lines not idled low");
    property p_clock_idle;
        @(posedge clk) disable iff (!reset_n) sync_n |-> !sclk;
    endproperty
    a_clock_idle: assert property (p_clock_idle) else $error("sclk high outside frame");
    // Main scenarios reached
    c_hiz: cover property (@(posedge clk) $changed(frame_done) && op_mode == SDMC_MODE_PD_HIZ);
    c_norm: cover property (@(posedge clk) $changed(frame_done) && op_mode == SDMC_MODE_NORMAL);
    c_start: cover property (@(posedge clk) $fell(sync_n));
endmodule : sdmc_link_monitor
`default_nettype wire

// ===== test/test_serial_dac_mode_control.sv
/*
 * Bench: host and converter joined by the link; frames sent over AHB-Lite.
 * Assumes zero wait states may occur but waits on hreadyout anyway.
 */
`default_nettype none
module test_serial_dac_mode_control
    import sdmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic          clk, reset_n, por_n, hsel, hwrite, hreadyout, hresp;
    logic [7:0]    haddr;
    logic [1:0]    htrans, mode;
    logic [2:0]    hsize;
    logic [31:0]   hwdata, hrdata, rd;
    logic [11:0]   dac_code, code;
    sdmc_mode_type op_mode;
    logic          analog_on, term_1k, term_100k, out_hiz, frame_done;
    logic [15:0]   seed;
    logic [1:0]    prev_mode;    // Mode of the frame before, for the wake expectation
    logic          saw_wake;     // Waking flag seen while polling
    int            num_errors, samples_checked;

    sdmc_link_if sdmc_link_if_i ();
    sdmc_host #(.WAKE_CYC(10)) sdmc_host_i (.clk(clk), .reset_n(reset_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .link(sdmc_link_if_i));
    sdmc_device sdmc_device_i (.link(sdmc_link_if_i), .por_n(por_n), .dac_code(dac_code),
        .op_mode(op_mode), .analog_on(analog_on), .term_1k(term_1k), .term_100k(term_100k),
        .out_hiz(out_hiz), .frame_done(frame_done));
    sdmc_link_monitor sdmc_link_monitor_i (.clk(clk), .reset_n(reset_n), .por_n(por_n),
        .sclk(sdmc_link_if_i.sclk), .sync_n(sdmc_link_if_i.sync_n), .din(sdmc_link_if_i.din),
        .dac_code(dac_code), .op_mode(op_mode), .analog_on(analog_on), .term_1k(term_1k),
        .term_100k(term_100k), .out_hiz(out_hiz), .frame_done(frame_done));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // Expected {analog_on, term_1k, term_100k, out_hiz} for a mode
    function automatic logic [3:0] exp_term(input logic [1:0] m);
        return {m == 2'b00, m == 2'b01, m == 2'b10, m == 2'b11};
    endfunction : exp_term
    task automatic finish_test;
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Bounded wait; a hang counts as a mismatch
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (hreadyout !== 1'b1) begin
            num_errors++;
            finish_test();
        end
    endtask : wait_ready
    // One single word transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : bus
    // Write a frame, then poll until busy and waking are both clear
    task automatic send(input logic [15:0] w);
        int n;
        bus(1'b1, SDMC_ADDR_DATA, {16'h0000, w});
        saw_wake = 1'b0;
        n = 0;
        do begin
            bus(1'b0, SDMC_ADDR_STATUS, 32'h0);
            saw_wake = saw_wake | rd[1];
            n++;
        end while (rd[0] !== 1'b1 && n < 10);
        // A frame that never starts is a hang as well
        if (rd[0] !== 1'b1) begin
            num_errors++;
            finish_test();
        end
        n = 0;
        do begin
            bus(1'b0, SDMC_ADDR_STATUS, 32'h0);
            saw_wake = saw_wake | rd[1];
            n++;
        end while (rd[1:0] !== 2'b00 && n < 500);
        if (rd[1:0] !== 2'b00) begin
            num_errors++;
            finish_test();
        end
    endtask : send
    task automatic expect_state(input logic [11:0] c, input logic [1:0] m);
        check(dac_code, c);
        check(op_mode, m);
        check({analog_on, term_1k, term_100k, out_hiz}, exp_term(m));
    endtask : expect_state

    // ------------------------------------------------------------------
    // Clock and main sequence
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        {reset_n, por_n, hsel, hwrite, haddr, htrans, hwdata} = '0;
        hsize = 3'b010;
        seed = 16'h004a;
        code = 12'h000;
        prev_mode = 2'b00;
        saw_wake = 1'b0;
        num_errors = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        por_n <= 1'b1;
        @(posedge clk);
        expect_state(12'h000, 2'b00);
        $display("test power_on done");
        // Every mode in order, then random; byte units on some frames
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            mode = (i < 8) ? i[1:0] : seed[13:12];
            if (mode == 2'b00) begin
                code = seed[11:0];
            end
            bus(1'b1, SDMC_ADDR_CTRL, {31'h0, i[2]});
            send({seed[15:14], mode, code});
            expect_state(code, mode);
            check(rd[3:2], mode);
            check(saw_wake, prev_mode != 2'b00 && mode == 2'b00);
            prev_mode = mode;
        end
        $display("test frames done");
        // Second write while busy is dropped; power-down to normal raises the waking flag
        bus(1'b1, SDMC_ADDR_DATA, 32'h0000_35a5);
        send(16'h0123);
        expect_state(12'h5a5, 2'b11);
        send(16'h05a5);
        expect_state(12'h5a5, 2'b00);
        check(saw_wake, 1'b1);
        $display("test refused and wake done");
        bus(1'b0, 8'h0c, 32'h0);
        check(rd, 32'h0);
        check(hresp, 32'h0);
        $display("test unmapped done");
        finish_test();
    end
endmodule : test_serial_dac_mode_control
`default_nettype wire
